// >>> src/fcd_dma.sv
/*
  Four-channel DMA engine: register port, per-channel state, arbiter and
  one read/write bus master. Assumes triggers, the processor bus request
  and the memory port all live on mclk_i; memory read data arrive one
  cycle after the read strobe.
*/
`timescale 1ns/1ps
module fcd_dma
  import fcd_pkg::*;
(
  input  wire logic              mclk_i,        // 200 MHz clock
  input  wire logic              rst_i,         // Async reset, high
  input  wire logic [AW-1:0]     reg_addr_i,    // Register word index
  input  wire logic [DW-1:0]     reg_wdata_i,   // Register write data
  input  wire logic              reg_wr_i,      // Write strobe
  input  wire logic              reg_rd_i,      // Read strobe
  output logic      [DW-1:0]     reg_rdata_o,   // Read data, next cycle
  input  wire logic [NTRIG-1:0]  trig_i,        // Trigger pulses
  input  wire logic              cpu_bus_req_i, // Processor wants bus
  input  wire logic [NCH*DW-1:0] periph_offset_i, // Peripheral offsets
  input  wire logic [DW-1:0]     mem_rdata_i,   // Memory read data
  output logic                   mem_rd_o,      // Memory read strobe
  output logic                   mem_wr_o,      // Memory write strobe
  output logic      [DW-1:0]     mem_addr_o,    // Byte address
  output logic      [DW-1:0]     mem_wdata_o,   // Write data
  output logic      [1:0]        mem_be_o,      // Byte lanes
  output logic      [NCH-1:0]    ch_irq_o,      // Channel event level
  output logic      [NCH-1:0]    ch_done_o      // Count end pulse
);

  // Channel register decode, shared by writes and reads
  function automatic logic fcd_hit(input logic [AW-1:0] a, input int ch, input logic [2:0] sub);
    fcd_hit = (a == AW'(OFS_CHBASE + ch * OFS_CHSTEP + sub));
  endfunction

  // Lowest set bit of a request vector
  function automatic logic [2:0] fcd_first(input logic [NCH-1:0] v);
    fcd_first = 3'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (v[k]) begin
        fcd_first = {1'b1, 2'(k)};
      end
    end
  endfunction

  // Limit check: {above, below}; register space is never checked
  function automatic logic [1:0] fcd_lim(input logic [DW-1:0] a, input logic [DW-1:0] lo,
                                         input logic [DW-1:0] hi);
    fcd_lim = 2'b00;
    if (a >= RAM_BASE) begin                                      // [RULE3] [RULE4]
      fcd_lim = {(a > hi) || (a > RAM_TOP), a < lo};
    end
  endfunction

  // Global state
  logic             en_reg;    // Engine enable
  logic             prs_reg;   // Round robin when set
  logic [DW-1:0]    upper_address_limit;
  logic [DW-1:0]    lower_address_limit;
  logic [DW-1:0]    buf_reg;   // Last data moved
  fcd_state_e       st_reg;    // Bus master state
  logic [1:0]       cur_reg;   // Channel in service
  logic [1:0]       last_reg;  // Last granted channel
  logic [DW-1:0]    sa_reg;    // Effective source
  logic [DW-1:0]    da_reg;    // Effective destination
  logic             byte_reg;  // Byte transfer
  logic             nw_reg;    // Null write pending
  logic             due_reg;   // Read data on the bus now

  // Per-channel views
  logic [NCH-1:0]   req;       // Wants the engine
  logic [DW-1:0]    eff_src [NCH];
  logic [DW-1:0]    eff_dst [NCH];
  logic [DW-1:0]    rd_ch   [NCH];
  logic [NCH-1:0]   size_ch;
  logic [NCH-1:0]   dummy_wr_ch;
  logic [NCH-1:0]   irq_ch;
  logic [NCH-1:0]   done_ch;

  // Trigger vector padded to the select range
  wire [127:0] trig_pad = {(128 - NTRIG)'(0), trig_i};

  // Arbiter: round robin rotates after the last grant
  wire [3:0]     last_p1 = 4'(last_reg) + 4'h1;
  wire [7:0]     rr_dbl  = {req, req} >> last_p1;
  wire [2:0]     rr_pick = fcd_first(rr_dbl[3:0]);
  wire [1:0]     rr_idx  = 2'(rr_pick[1:0] + last_p1[1:0]);        // [RULE17]
  wire [NCH-1:0] fx_msk  = req & ~(4'b0001 << last_reg);           // [RULE18]
  wire [NCH-1:0] fx_req  = (fx_msk != 4'h0) ? fx_msk : req;        // [RULE19]
  wire [2:0]     fx_pick = fcd_first(fx_req);
  wire [1:0]     g_idx   = prs_reg ? rr_idx : fx_pick[1:0];        // [RULE23]
  wire           g_any   = (req != 4'h0);

  // Grant is taken only while the processor leaves the bus alone
  wire           can_go  = en_reg && (st_reg == FCD_ST_IDLE) && !cpu_bus_req_i; // [RULE20] [RULE21]
  wire           grant   = can_go && g_any;
  wire [1:0]     lim_s   = fcd_lim(eff_src[g_idx], lower_address_limit, upper_address_limit);
  wire [1:0]     lim_d   = fcd_lim(eff_dst[g_idx], lower_address_limit, upper_address_limit);
  wire           lim_hi  = lim_s[1] | lim_d[1];
  wire           lim_lo  = lim_s[0] | lim_d[0];
  wire           abort   = grant && (lim_hi || lim_lo);            // [RULE5]
  wire           start   = grant && !abort;

  // End of one transfer, seen for one cycle
  wire xfer_end = en_reg && (((st_reg == FCD_ST_WR) && !nw_reg) || (st_reg == FCD_ST_NW));

  // Write data lane handling
  wire [DW-1:0] wsrc  = due_reg ? mem_rdata_i : buf_reg;
  wire [7:0]    wbyte = sa_reg[0] ? wsrc[15:8] : wsrc[7:0];         // [RULE7]
  wire [DW-1:0] wdat  = byte_reg ? {wbyte, wbyte} : wsrc;           // [RULE6]
  wire [1:0]    wbe_d = byte_reg ? (da_reg[0] ? 2'b10 : 2'b01) : 2'b11;
  wire [1:0]    wbe_s = byte_reg ? (sa_reg[0] ? 2'b10 : 2'b01) : 2'b11;
  wire [1:0]    rbe   = size_ch[g_idx] ? (eff_src[g_idx][0] ? 2'b10 : 2'b01) : 2'b11;

  // Global register writes
  wire wr_ctrl  = reg_wr_i && (reg_addr_i == OFS_CTRL);
  wire wr_upper = reg_wr_i && (reg_addr_i == OFS_UPPER);
  wire wr_lower = reg_wr_i && (reg_addr_i == OFS_LOWER);

  // Engine control and limit registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg              <= 1'b0;
      prs_reg             <= 1'b0;
      upper_address_limit <= RST_WORD;
      lower_address_limit <= RST_WORD;
    end else begin
      if (wr_ctrl) begin
        en_reg  <= reg_wdata_i[CTRL_EN];
        prs_reg <= reg_wdata_i[CTRL_PRS];
      end
      if (wr_upper) begin
        upper_address_limit <= reg_wdata_i;
      end
      if (wr_lower) begin
        lower_address_limit <= reg_wdata_i;
      end
    end
  end

  // Bus master sequence: read, data, write, optional null write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg      <= FCD_ST_IDLE;
      cur_reg     <= 2'h0;
      last_reg    <= RST_LAST;
      sa_reg      <= RST_WORD;
      da_reg      <= RST_WORD;
      byte_reg    <= 1'b0;
      nw_reg      <= 1'b0;
      due_reg     <= 1'b0;
      buf_reg     <= RST_WORD;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= RST_WORD;
      mem_wdata_o <= RST_WORD;
      mem_be_o    <= 2'b00;
    end else begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      due_reg  <= (st_reg == FCD_ST_RD);
      if (due_reg) begin
        buf_reg <= mem_rdata_i;
      end
      if (!en_reg) begin
        // Engine off drops any transfer in flight
        st_reg <= FCD_ST_IDLE;                                       // [RULE24]
      end else begin
        unique case (st_reg)
          FCD_ST_IDLE: begin
            if (grant) begin
              last_reg <= g_idx;
              cur_reg  <= g_idx;
            end
            if (start) begin
              sa_reg     <= eff_src[g_idx];
              da_reg     <= eff_dst[g_idx];
              byte_reg   <= size_ch[g_idx];
              nw_reg     <= dummy_wr_ch[g_idx];
              mem_rd_o   <= 1'b1;
              mem_addr_o <= eff_src[g_idx];
              mem_be_o   <= rbe;
              st_reg     <= FCD_ST_RD;
            end
          end
          FCD_ST_RD: begin
            st_reg <= FCD_ST_DAT;
          end
          FCD_ST_DAT: begin
            // Data are held in the buffer while the processor owns the bus
            if (!cpu_bus_req_i) begin                                // [RULE20]
              mem_wr_o    <= 1'b1;
              mem_addr_o  <= da_reg;
              mem_wdata_o <= wdat;
              mem_be_o    <= wbe_d;
              st_reg      <= FCD_ST_WR;
            end
          end
          FCD_ST_WR: begin
            if (!nw_reg) begin
              st_reg <= FCD_ST_IDLE;
            end else if (!cpu_bus_req_i) begin
              mem_wr_o   <= 1'b1;                                    // [RULE26]
              mem_addr_o <= sa_reg;
              mem_be_o   <= wbe_s;
              st_reg     <= FCD_ST_NW;
            end
          end
          FCD_ST_NW: begin
            st_reg <= FCD_ST_IDLE;
          end
          default: begin
            st_reg <= FCD_ST_IDLE;
          end
        endcase
      end
    end
  end

  // One copy of channel state per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch                     // [RULE1]
    logic [CH_W-1:0] channel_control_reg;
    logic [DW-1:0]   source_address_reg;
    logic [DW-1:0]   destination_address_reg;
    logic [DW-1:0]   transaction_counter;
    logic [DW-1:0]   src0_reg;  // Start values for reload
    logic [DW-1:0]   dst0_reg;
    logic [DW-1:0]   cnt0_reg;
    logic [TSW-1:0]  tsel_reg;
    logic [4:0]      flag_reg;  // hi, lo, done, half, overrun
    logic            halfen_reg;
    logic            pend_reg;  // Trigger waiting
    logic            irq_reg;
    logic            done_reg;

    wire             ch_on = en_reg && channel_control_reg[CH_EN];
    wire [1:0]       trm   = channel_control_reg[CH_TRM +: 2];
    wire [1:0]       sam   = channel_control_reg[CH_SAM +: 2];
    wire [1:0]       dam   = channel_control_reg[CH_DAM +: 2];
    wire [DW-1:0]    step  = channel_control_reg[CH_SIZE] ? 16'h0001 : 16'h0002;
    wire [DW-1:0]    off   = periph_offset_i[i*DW +: DW];
    wire             trig  = trig_pad[tsel_reg];                   // [RULE8] [RULE9]
    wire             take  = ch_on && trig;                         // [RULE27]
    wire             mine  = xfer_end && (cur_reg == 2'(i));
    wire             myab  = abort && (g_idx == 2'(i));
    wire             last  = (transaction_counter <= 16'h0001);
    wire             rep   = trm[0];                                 // [RULE25]
    wire             cont  = trm[1];
    wire             cnt_end  = mine && last;                        // [RULE28]
    wire             unit_end = mine && (!cont || last);             // [RULE10] [RULE11]
    wire [DW-1:0]    cnt_dec  = transaction_counter - 16'h0001;
    wire             halfhit  = mine && !last && (cnt_dec == (cnt0_reg >> 1));
    wire             reload   = channel_control_reg[CH_RELD];
    wire             wr_ch  = reg_wr_i && fcd_hit(reg_addr_i, i, SUB_CH);
    wire             wr_int = reg_wr_i && fcd_hit(reg_addr_i, i, SUB_INT);
    wire             wr_src = reg_wr_i && fcd_hit(reg_addr_i, i, SUB_SRC);
    wire             wr_dst = reg_wr_i && fcd_hit(reg_addr_i, i, SUB_DST);
    wire             wr_cnt = reg_wr_i && fcd_hit(reg_addr_i, i, SUB_CNT);
    wire [4:0]       fset   = {myab && lim_hi, myab && lim_lo, cnt_end,
                               halfhit && halfen_reg,
                               take && pend_reg && !(unit_end || myab)}; // [RULE22]

    // Block modes step the address, fixed and indirect keep it
    wire [DW-1:0] src_nx = (sam == FCD_AM_INC) ? source_address_reg + step :
                           (sam == FCD_AM_DEC) ? source_address_reg - step : source_address_reg; // [RULE15]
    wire [DW-1:0] dst_nx = (dam == FCD_AM_INC) ? destination_address_reg + step :
                           (dam == FCD_AM_DEC) ? destination_address_reg - step : destination_address_reg;

    // Indirect mode adds the peripheral's offset to the base
    assign eff_src[i] = (sam == FCD_AM_IND) ? source_address_reg + off : source_address_reg;       // [RULE16]
    assign eff_dst[i] = (dam == FCD_AM_IND) ? destination_address_reg + off : destination_address_reg;
    assign req[i]      = ch_on && (pend_reg || channel_control_reg[CH_REQ]) && !(st_reg != FCD_ST_IDLE
                         && cur_reg == 2'(i));
    assign size_ch[i]  = channel_control_reg[CH_SIZE];
    assign dummy_wr_ch[i] = channel_control_reg[CH_DUMMY_WR];
    assign irq_ch[i]   = irq_reg;
    assign done_ch[i]  = done_reg;
    assign rd_ch[i] =
      fcd_hit(reg_addr_i, i, SUB_CH)  ? {5'h00, channel_control_reg} :
      fcd_hit(reg_addr_i, i, SUB_INT) ? {1'b0, tsel_reg, flag_reg, 2'b00, halfen_reg} :
      fcd_hit(reg_addr_i, i, SUB_SRC) ? source_address_reg :
      fcd_hit(reg_addr_i, i, SUB_DST) ? destination_address_reg :
      fcd_hit(reg_addr_i, i, SUB_CNT) ? transaction_counter : RST_WORD;

    // Hardware updates first, software writes next, flag sets win last
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        channel_control_reg     <= RST_CH;
        source_address_reg      <= RST_WORD;
        destination_address_reg <= RST_WORD;
        transaction_counter     <= RST_WORD;
        src0_reg                <= RST_WORD;
        dst0_reg                <= RST_WORD;
        cnt0_reg                <= RST_WORD;
        tsel_reg                <= '0;
        flag_reg                <= 5'h00;
        halfen_reg              <= 1'b0;
        pend_reg                <= 1'b0;
        irq_reg                 <= 1'b0;
        done_reg                <= 1'b0;
      end else begin
        done_reg <= cnt_end;
        irq_reg  <= (flag_reg != 5'h00);
        if (!en_reg) begin
          pend_reg                    <= 1'b0;                       // [RULE24]
          channel_control_reg[CH_REQ] <= 1'b0;
        end
        if (unit_end || myab) begin
          pend_reg                    <= 1'b0;                       // [RULE5]
          channel_control_reg[CH_REQ] <= 1'b0;
        end
        // Set after the clears: a trigger in the closing cycle is kept
        if (take) begin
          pend_reg <= 1'b1;                                          // [RULE27]
        end
        if (mine && !last) begin
          transaction_counter     <= cnt_dec;                       // [RULE2]
          source_address_reg      <= src_nx;
          destination_address_reg <= dst_nx;
        end
        if (cnt_end) begin
          // Count exhausted: restore or stop
          transaction_counter     <= (reload || rep) ? cnt0_reg : cnt_dec; // [RULE12] [RULE13]
          source_address_reg      <= reload ? src0_reg : src_nx;   // [RULE14]
          destination_address_reg <= reload ? dst0_reg : dst_nx;
          if (!rep) begin
            channel_control_reg[CH_EN] <= 1'b0;
          end
        end
        if (wr_ch) begin
          channel_control_reg <= reg_wdata_i[CH_W-1:0];             // [RULE6]
        end
        if (wr_src) begin
          source_address_reg <= reg_wdata_i;
          src0_reg           <= reg_wdata_i;
        end
        if (wr_dst) begin
          destination_address_reg <= reg_wdata_i;
          dst0_reg                <= reg_wdata_i;
        end
        if (wr_cnt) begin
          transaction_counter <= reg_wdata_i;
          cnt0_reg            <= reg_wdata_i;
        end
        if (wr_int) begin
          tsel_reg   <= reg_wdata_i[INT_TSEL +: TSW];
          halfen_reg <= reg_wdata_i[INT_HEN];
          flag_reg   <= reg_wdata_i[INT_OVR +: 5] | fset;
        end else begin
          flag_reg <= flag_reg | fset;
        end
      end
    end
  end

  // Read data selection
  logic [DW-1:0] rd_any;
  always_comb begin
    rd_any = RST_WORD;
    for (int k = 0; k < NCH; k++) begin
      rd_any = rd_any | rd_ch[k];
    end
  end
  wire [DW-1:0] rd_mux =
    (reg_addr_i == OFS_CTRL)  ? {en_reg, 14'h0000, prs_reg} :
    (reg_addr_i == OFS_BUF)   ? buf_reg :
    (reg_addr_i == OFS_UPPER) ? upper_address_limit :
    (reg_addr_i == OFS_LOWER) ? lower_address_limit : rd_any;

  // Registered outputs; unmapped reads give zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= RST_WORD;
      ch_irq_o    <= '0;
      ch_done_o   <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : RST_WORD;
      ch_irq_o    <= irq_ch;
      ch_done_o   <= done_ch;
    end
  end

endmodule // fcd_dma

// >>> src/fcd_pkg.sv
/*
  Constants, field layouts, modes and states of the four-channel DMA engine.
  Assumes a 16-bit register port with word-indexed addresses.
*/
// What this block does
// [RULE1] Four independent channels, each separately programmed
// [RULE2] Per-channel 16-bit source, destination, counter, reloadable
// [RULE3] Endpoints in register space or RAM
// [RULE4] RAM accesses checked against upper/lower limits
// [RULE5] Limit violation terminates transaction, flags interrupt
// [RULE6] Byte or word size; word after reset
// [RULE7] Byte transfers: address LSB picks byte lane
// [RULE8] Trigger chosen from 82 interrupt sources
// [RULE9] Trigger independent of addresses; channels can cascade
// [RULE10] One-shot: one transaction per trigger
// [RULE11] Continuous: counter-sized burst per trigger
// [RULE12] Repeated one-shot: one per trigger until disabled
// [RULE13] Repeated continuous: burst per trigger until disabled
// [RULE14] Optional reload of addresses and counter
// [RULE15] Fixed or block addressing, increment or decrement
// [RULE16] Peripheral indirect: base plus peripheral offset
// [RULE17] Round robin: lower first, then rotate upward
// [RULE18] Fixed: lowest wins, just-served channel skipped
// [RULE19] Fixed: busy high channel yields to next lower
// [RULE20] Yield the bus when processor needs it
// [RULE21] Never stall the processor
// [RULE22] Half-count interrupt per channel
// [RULE23] Scheme bit: 1 round robin, 0 fixed
// [RULE24] Module disable aborts all channels at once
// [RULE25] Mode codes 00,01,10,11 as listed; the code takes 01 as repeated one-shot and 10 as continuous
// [RULE26] Null write: dummy write to source too
// [RULE27] Disabled channel ignores triggers and requests
// [RULE28] Count down per transfer; at end complete, reload
package fcd_pkg;
  localparam int NCH   = 4;  // Channel count
  localparam int AW    = 8;  // Register port address width
  localparam int DW    = 16; // Data width
  localparam int NTRIG = 82; // Trigger sources
  localparam int TSW   = 7;  // Trigger select width

  // Register map, word indexed
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_BUF    = 8'h01;
  localparam logic [AW-1:0] OFS_UPPER  = 8'h02;
  localparam logic [AW-1:0] OFS_LOWER  = 8'h03;
  localparam logic [AW-1:0] OFS_CHBASE = 8'h10;
  localparam logic [AW-1:0] OFS_CHSTEP = 8'h08;
  localparam logic [2:0]    SUB_CH     = 3'h0;
  localparam logic [2:0]    SUB_INT    = 3'h1;
  localparam logic [2:0]    SUB_SRC    = 3'h2;
  localparam logic [2:0]    SUB_DST    = 3'h3;
  localparam logic [2:0]    SUB_CNT    = 3'h4;

  // Engine control fields
  localparam int CTRL_EN  = 15;
  localparam int CTRL_PRS = 0;
  // Channel control fields
  localparam int CH_DUMMY_WR = 10; // Dummy write to source
  localparam int CH_RELD  = 9;
  localparam int CH_REQ   = 8;
  localparam int CH_SAM   = 6;
  localparam int CH_DAM   = 4;
  localparam int CH_TRM   = 2;
  localparam int CH_SIZE  = 1;
  localparam int CH_EN    = 0;
  localparam int CH_W     = 11;
  // Channel interrupt fields
  localparam int INT_TSEL = 8;
  localparam int INT_HI   = 7;
  localparam int INT_LO   = 6;
  localparam int INT_DONE = 5;
  localparam int INT_HALF = 4;
  localparam int INT_OVR  = 3;
  localparam int INT_HEN  = 0;

  // Reset values
  localparam logic [DW-1:0]   RST_WORD = 16'h0000;
  localparam logic [CH_W-1:0] RST_CH   = 11'h000;
  localparam logic [1:0]      RST_LAST = 2'h3;

  // Address spaces
  localparam logic [DW-1:0] RAM_BASE = 16'h1000;
  localparam logic [DW-1:0] RAM_TOP  = 16'h4fff;

  typedef enum logic [1:0] {
    FCD_TR_ONE  = 2'b00,
    FCD_TR_RONE = 2'b01,
    FCD_TR_CONT = 2'b10,
    FCD_TR_RCON = 2'b11
  } fcd_trmode_e;

  typedef enum logic [1:0] {
    FCD_AM_FIX = 2'b00,
    FCD_AM_INC = 2'b01,
    FCD_AM_DEC = 2'b10,
    FCD_AM_IND = 2'b11
  } fcd_amode_e;

  typedef enum logic [2:0] {
    FCD_ST_IDLE = 3'b000,
    FCD_ST_RD   = 3'b001,
    FCD_ST_DAT  = 3'b011,
    FCD_ST_WR   = 3'b010,
    FCD_ST_NW   = 3'b110
  } fcd_state_e;
endpackage

// >>> bench/fcd_dma_asserts.sv
/*
  Port checker for the four-channel DMA engine.
  Bound to fcd_dma; one clock domain, async high reset.
*/
`timescale 1ns/1ps
module fcd_dma_asserts
  import fcd_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             rst_i,
  input wire logic             reg_rd_i,
  input wire logic [DW-1:0]    reg_rdata_o,
  input wire logic             cpu_bus_req_i,
  input wire logic             mem_rd_o,
  input wire logic             mem_wr_o,
  input wire logic [DW-1:0]    mem_addr_o,
  input wire logic [DW-1:0]    mem_wdata_o,
  input wire logic [1:0]       mem_be_o,
  input wire logic [NCH-1:0]   ch_done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // One bus cycle at a time
  rd_wr_excl_a: assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write strobes together");
  // Processor claim holds off every new strobe
  cpu_yield_a: assert property (cpu_bus_req_i |=> !mem_rd_o && !mem_wr_o)
    else $error("strobe while processor owns bus");
  // Read data only right after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  // Reads spaced at least four cycles
  rd_gap_a: assert property (mem_rd_o |=> !mem_rd_o [*3])
    else $error("reads too close");
  // A read with the processor idle for two cycles is followed by its write
  rd_to_wr_a: assert property ((mem_rd_o && !cpu_bus_req_i) ##1 !cpu_bus_req_i |=> mem_wr_o)
    else $error("write missing after read");
  // Byte lane follows address bit 0
  byte_lane_a: assert property ((mem_rd_o || mem_wr_o) && mem_be_o != 2'b11 |->
    mem_be_o == {mem_addr_o[0], !mem_addr_o[0]}) else $error("wrong byte lane");
  // Byte writes carry the byte in both lanes
  byte_dup_a: assert property (mem_wr_o && mem_be_o != 2'b11 |->
    mem_wdata_o[15:8] == mem_wdata_o[7:0]) else $error("byte not duplicated");
  // Count end only within three cycles after a write
  done_after_wr_a: assert property (|ch_done_o |->
    $past(mem_wr_o) || $past(mem_wr_o, 2) || $past(mem_wr_o, 3)) else $error("done without write");
  // Count end is a one-cycle pulse
  done_pulse_a: assert property (|ch_done_o |=> ch_done_o == '0)
    else $error("done pulse too long");

  rd_c: cover property (mem_rd_o ##2 mem_wr_o);
  byte_c: cover property (mem_wr_o && mem_be_o != 2'b11);
  done_c: cover property (|ch_done_o);
endmodule // fcd_dma_asserts

bind fcd_dma fcd_dma_asserts u_chk (.*);

// >>> bench/fcd_mem_model.sv
/*
  Word memory behind the DMA master, 512 words.
  Read data stand only in the cycle after a read strobe.
*/
`timescale 1ns/1ps
module fcd_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  be_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] ram [0:511]; // Bench preloads it directly

  // Lane writes; stale read data flips so it never passes as fresh
  always @(posedge mclk_i) begin
    if (mem_wr_i && be_i[0]) ram[addr_i[9:1]][7:0] <= wdata_i[7:0];
    if (mem_wr_i && be_i[1]) ram[addr_i[9:1]][15:8] <= wdata_i[15:8];
    rdata_o <= mem_rd_i ? ram[addr_i[9:1]] : ~rdata_o;
  end
endmodule // fcd_mem_model

// >>> bench/tb_four_channel_dma_controller.sv
/*
  Self-checking bench for fcd_dma with a memory model.
  Assumes the checker is bound and a 200 MHz clock.
*/
`timescale 1ns/1ps
module tb_four_channel_dma_controller;
  import fcd_pkg::*;
  logic              mclk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cpu_bus_req_i = 0;
  logic              mem_rd_o, mem_wr_o, noisy = 0;
  logic [AW-1:0]     reg_addr_i = '0;
  logic [DW-1:0]     reg_wdata_i = '0, reg_rdata_o, mem_rdata_i, mem_addr_o, mem_wdata_o, d, w;
  logic [NTRIG-1:0]  trig_i = '0;
  logic [NCH*DW-1:0] periph_offset_i = '0;
  logic [1:0]        mem_be_o;
  logic [NCH-1:0]    ch_irq_o, ch_done_o;
  int                errors = 0, checks = 0, rds = 0, wrs = 0, r0, k, seed = 32'h332717dc;

  always #2.5 mclk_i = ~mclk_i;
  fcd_dma dut (.*);
  fcd_mem_model mem (.mclk_i(mclk_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .addr_i(mem_addr_o),
                     .wdata_i(mem_wdata_o), .be_i(mem_be_o), .rdata_o(mem_rdata_i));

  // Count reads; random processor claims contend for the bus
  always @(posedge mclk_i) begin
    if (mem_rd_o) rds++;
    if (mem_wr_o) wrs++;
    cpu_bus_req_i <= noisy && ($random(seed) % 3 == 0);
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Channel register index and control word
  function logic [7:0] ca(input int n, input logic [2:0] s);
    return 8'(int'(OFS_CHBASE) + int'(OFS_CHSTEP) * n + int'(s));
  endfunction
  function logic [15:0] ctl(input logic [1:0] t, sm, dm, input logic z, q);
    return {5'h0, 2'b00, q, sm, dm, t, z, 1'b1};
  endfunction
  // Bounded wait for a count-end pulse
  task wait_done(input int n);
    int i;
    i = 0;
    do begin
      @(posedge mclk_i);
      #1 i++;
    end while (ch_done_o[n] !== 1'b1 && i < 400);
    chk("done", 16'(ch_done_o[n]), 16'h1);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog far beyond the expected run
  initial begin
    repeat (30000) @(posedge mclk_i);
    errors++;
    report_and_stop;
  end

  initial begin
    periph_offset_i <= {$random(seed), $random(seed)};
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(ca(0, SUB_CH));
    chk("ch_ctrl", d, 16'h0);
    k = $random(seed);
    wr(ca(3, SUB_SRC), k[15:0]);
    rd(ca(3, SUB_SRC));
    chk("src", d, k[15:0]);
    rd(8'hff);
    chk("unmapped", d, 16'h0);
    $display("test regs done");
    // Continuous null-write copy, round robin, processor steals the bus
    for (int i = 0; i < 8; i++) mem.ram[i] = 16'($random(seed));
    wr(OFS_UPPER, RAM_TOP);
    wr(OFS_LOWER, RAM_BASE);
    wr(OFS_CTRL, 16'h8001);
    wr(ca(0, SUB_SRC), 16'h1000);
    wr(ca(0, SUB_DST), 16'h1100);
    wr(ca(0, SUB_CNT), 16'h4);
    wr(ca(0, SUB_INT), 16'h0001);
    noisy = 1;
    r0 = rds;
    wr(ca(0, SUB_CH), ctl(FCD_TR_CONT, FCD_AM_INC, FCD_AM_INC, 1'b0, 1'b1) | 16'h0400);
    wait_done(0);
    noisy = 0;
    chk("cont_reads", 16'(rds - r0), 16'h4);
    chk("null_writes", 16'(wrs), 16'h8);
    rd(ca(0, SUB_INT));
    chk("half_flag", 16'(d[INT_HALF]), 16'h1);
    for (int i = 0; i < 4; i++) chk("copy", mem.ram[9'h80 + i], mem.ram[i]);
    rd(ca(0, SUB_CH));
    chk("ch_off", d & 16'h0101, 16'h0);
    $display("test block copy done");
    // Byte one-shot from a random trigger code, upper to lower lane
    k = {$random(seed)} % NTRIG;
    w = 16'($random(seed));
    mem.ram[9'h100] = w;
    wr(ca(1, SUB_INT), 16'(k) << INT_TSEL);
    wr(ca(1, SUB_SRC), 16'h1001);
    wr(ca(1, SUB_DST), 16'h1200);
    wr(ca(1, SUB_CNT), 16'h2);
    wr(ca(1, SUB_CH), ctl(FCD_TR_ONE, FCD_AM_FIX, FCD_AM_FIX, 1'b1, 1'b0));
    r0 = rds;
    @(posedge mclk_i);
    trig_i[k] <= 1'b1;
    @(posedge mclk_i);
    trig_i <= '0;
    repeat (20) @(posedge mclk_i);
    chk("oneshot_reads", 16'(rds - r0), 16'h1);
    chk("byte", mem.ram[9'h100], {w[15:8], mem.ram[0][15:8]});
    $display("test byte trigger done");
    // Source below the lower limit: no cycle, flag and irq
    wr(OFS_LOWER, 16'h2000);
    wr(ca(2, SUB_SRC), 16'h1000);
    wr(ca(2, SUB_DST), 16'h2100);
    r0 = rds;
    wr(ca(2, SUB_CH), ctl(FCD_TR_ONE, FCD_AM_FIX, FCD_AM_FIX, 1'b0, 1'b1));
    repeat (20) @(posedge mclk_i);
    chk("limit_reads", 16'(rds - r0), 16'h0);
    rd(ca(2, SUB_INT));
    chk("low_flag", 16'(d[INT_LO]), 16'h1);
    chk("irq", 16'(ch_irq_o[2]), 16'h1);
    $display("test limit done");
    report_and_stop;
  end
endmodule // tb_four_channel_dma_controller
